// file: hw/fabric_boot_ready_handshake.sv
// Boot handshake logic that qualifies and polls the fabric boot flag group for the boot ROM.
//
// What this block does
// - Accept a fabric input flag saying a preloader sits in fabric on-chip memory.
// - Accept a separate fabric flag saying a fallback preloader exists in fabric memory.
// - Poll the active-high memory-ready flag before writing fabric memory at offset zero.
// - Force memory-ready low while the fabric is unconfigured, preventing false ready.
// - Read a fabric-held public key only while memory-ready is asserted; otherwise ignore it.
// - Poll the fallback-available flag once every preloader source has failed.
// - Hold fallback-available low whenever the fabric is not configured.
// - Keep polling both flags without limit; proceed only when both read set.
`timescale 1ns/10ps
module fabric_boot_ready_handshake
    import fabric_boot_pkg::*;
(
    input  wire logic                        clock,
    input  wire logic                        reset_n,
    input  wire logic                        fabricConfigured,
    input  wire logic                        fabricMemoryReadyFlag,
    input  wire logic                        fallbackImageAvailableFlag,
    input  wire logic                        fabricBootRequest,
    input  wire logic                        allSourcesFailed,
    input  wire logic                        publicKeyInFabric,
    output logic                             memoryReadyStatus,
    output logic                             fallbackAvailableStatus,
    output logic                             fabricBootGo,
    output logic                             pollActive,
    output logic                             keyReadEnable,
    output logic                             keyWithheld,
    output logic [POLL_COUNT_WIDTH-1:0]      pollAttempts
);

    // ========================================================================
    // Synchronisation of the fabric flags
    // ========================================================================
    flag_sync_if syncBus ();

    assign syncBus.rawFlags[FLAG_CONFIGURED] = fabricConfigured;
    assign syncBus.rawFlags[FLAG_MEM_READY]  = fabricMemoryReadyFlag;
    assign syncBus.rawFlags[FLAG_FALLBACK]   = fallbackImageAvailableFlag;

    flag_synchronizer u_flag_synchronizer (
        .clock   (clock),
        .reset_n (reset_n),
        .flags   (syncBus.synchronizer)
    );

    // A flag only counts while the fabric reports itself configured, so a half-loaded
    // fabric with floating outputs can never fake a ready indication.
    function automatic logic gateFlag(input logic [FLAG_COUNT-1:0] f, input int idx);
        gateFlag = f[idx] & f[FLAG_CONFIGURED];
    endfunction

    logic readyLive;
    logic fallbackLive;

    assign readyLive    = gateFlag(syncBus.syncFlags, FLAG_MEM_READY);
    assign fallbackLive = gateFlag(syncBus.syncFlags, FLAG_FALLBACK);

    // ========================================================================
    // Poll sequencer
    // ========================================================================
    poll_state_t                  state_r;
    poll_state_t                  state_nxt;
    logic [POLL_TIMER_WIDTH-1:0]  timer_r;
    logic [POLL_TIMER_WIDTH-1:0]  timer_nxt;
    logic [POLL_COUNT_WIDTH-1:0]  attempts_r;
    logic [POLL_COUNT_WIDTH-1:0]  attempts_nxt;
    logic                         readySample_r;
    logic                         readySample_nxt;
    logic                         fallbackSample_r;
    logic                         fallbackSample_nxt;
    logic                         wantFabric;
    logic                         pollTick;

    // Either a direct fabric boot or the last-resort fallback starts polling.
    assign wantFabric = fabricBootRequest | allSourcesFailed;
    assign pollTick   = (timer_r == POLL_TIMER_RESET);

    always_comb begin
        state_nxt          = state_r;
        timer_nxt          = timer_r;
        attempts_nxt       = attempts_r;
        readySample_nxt    = readySample_r;
        fallbackSample_nxt = fallbackSample_r;
        unique case (state_r)
            POLL_IDLE: begin
                // The first poll happens on the first cycle in POLL_WAIT.
                timer_nxt          = POLL_TIMER_RESET;
                readySample_nxt    = FLAG_RESET;
                fallbackSample_nxt = FLAG_RESET;
                if (wantFabric) begin
                    state_nxt    = POLL_WAIT;
                    attempts_nxt = POLL_COUNT_RESET;
                end
            end
            POLL_WAIT: begin
                if (!wantFabric) begin
                    state_nxt = POLL_IDLE;
                end else if (pollTick) begin
                    // Sampling is periodic, which is why the fabric must hold its flags steady.
                    timer_nxt          = POLL_INTERVAL_CYCLES - 7'h01;
                    readySample_nxt    = readyLive;
                    fallbackSample_nxt = fallbackLive;
                    if (attempts_r != POLL_COUNT_MAX) begin
                        attempts_nxt = attempts_r + 16'h0001;
                    end
                    // No timeout: the sequencer waits here for as long as it takes.
                    if (readyLive && fallbackLive) begin
                        state_nxt = POLL_GRANT;
                    end
                end else begin
                    timer_nxt = timer_r - 7'h01;
                end
            end
            POLL_GRANT: begin
                readySample_nxt    = readyLive;
                fallbackSample_nxt = fallbackLive;
                if (!wantFabric) begin
                    state_nxt = POLL_IDLE;
                end else if (!(readyLive && fallbackLive)) begin
                    // Fabric lost configuration or dropped a flag: go back to polling.
                    state_nxt = POLL_WAIT;
                    timer_nxt = POLL_TIMER_RESET;
                end
            end
            default: begin
                state_nxt = POLL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_r          <= POLL_IDLE;
            timer_r          <= POLL_TIMER_RESET;
            attempts_r       <= POLL_COUNT_RESET;
            readySample_r    <= FLAG_RESET;
            fallbackSample_r <= FLAG_RESET;
        end else begin
            state_r          <= state_nxt;
            timer_r          <= timer_nxt;
            attempts_r       <= attempts_nxt;
            readySample_r    <= readySample_nxt;
            fallbackSample_r <= fallbackSample_nxt;
        end
    end

    // ========================================================================
    // Registered outputs
    // ========================================================================
    logic memoryReady_r;
    logic memoryReady_nxt;
    logic fallbackAvail_r;
    logic fallbackAvail_nxt;
    logic bootGo_r;
    logic bootGo_nxt;
    logic pollActive_r;
    logic pollActive_nxt;
    logic keyRead_r;
    logic keyRead_nxt;
    logic keyWithheld_r;
    logic keyWithheld_nxt;

    always_comb begin
        memoryReady_nxt   = readyLive;
        fallbackAvail_nxt = fallbackLive;
        bootGo_nxt        = (state_nxt == POLL_GRANT);
        pollActive_nxt    = (state_nxt == POLL_WAIT);
        // The key path follows the live flag so a dropped ready stops key reads at once.
        keyRead_nxt       = publicKeyInFabric && (state_nxt != POLL_IDLE) && readyLive;
        keyWithheld_nxt   = publicKeyInFabric && (state_nxt != POLL_IDLE) && !readyLive;
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            memoryReady_r   <= FLAG_RESET;
            fallbackAvail_r <= FLAG_RESET;
            bootGo_r        <= FLAG_RESET;
            pollActive_r    <= FLAG_RESET;
            keyRead_r       <= FLAG_RESET;
            keyWithheld_r   <= FLAG_RESET;
        end else begin
            memoryReady_r   <= memoryReady_nxt;
            fallbackAvail_r <= fallbackAvail_nxt;
            bootGo_r        <= bootGo_nxt;
            pollActive_r    <= pollActive_nxt;
            keyRead_r       <= keyRead_nxt;
            keyWithheld_r   <= keyWithheld_nxt;
        end
    end

    assign memoryReadyStatus       = memoryReady_r;
    assign fallbackAvailableStatus = fallbackAvail_r;
    assign fabricBootGo            = bootGo_r;
    assign pollActive              = pollActive_r;
    assign keyReadEnable           = keyRead_r;
    assign keyWithheld             = keyWithheld_r;
    assign pollAttempts            = attempts_r;

endmodule // fabric_boot_ready_handshake

// file: hw/fabric_boot_pkg.sv
// Constants and types shared by the fabric boot handshake design files.
package fabric_boot_pkg;

    // ========================================================================
    // Flag positions on the synchroniser vector
    // ========================================================================
    localparam int FLAG_COUNT       = 3;
    localparam int FLAG_CONFIGURED  = 0;
    localparam int FLAG_MEM_READY   = 1;
    localparam int FLAG_FALLBACK    = 2;
    localparam int SYNC_STAGES      = 2;

    // ========================================================================
    // Timing
    // ========================================================================
    localparam int CLOCK_PERIOD_NS  = 10;
    localparam int POLL_INTERVAL_NS = 1000;
    localparam int POLL_TIMER_WIDTH = 7;
    localparam logic [POLL_TIMER_WIDTH-1:0] POLL_INTERVAL_CYCLES =
        POLL_TIMER_WIDTH'(POLL_INTERVAL_NS / CLOCK_PERIOD_NS);
    localparam logic [POLL_TIMER_WIDTH-1:0] POLL_TIMER_RESET = 7'h00;

    // ========================================================================
    // Counters and reset values
    // ========================================================================
    localparam int POLL_COUNT_WIDTH = 16;
    localparam logic [POLL_COUNT_WIDTH-1:0] POLL_COUNT_RESET = 16'h0000;
    localparam logic [POLL_COUNT_WIDTH-1:0] POLL_COUNT_MAX   = 16'hffff;
    localparam logic [FLAG_COUNT-1:0]       SYNC_RESET       = 3'h0;
    localparam logic                        FLAG_RESET       = 1'h0;

    // ========================================================================
    // Poll sequencer states
    // ========================================================================
    typedef enum logic [1:0] {
        POLL_IDLE  = 2'h0,
        POLL_WAIT  = 2'h1,
        POLL_GRANT = 2'h3
    } poll_state_t;

endpackage : fabric_boot_pkg

// file: hw/flag_sync_if.sv
// Interface carrying the raw fabric flags into the synchroniser and the clean copies back out.
`timescale 1ns/10ps
interface flag_sync_if;
    import fabric_boot_pkg::*;

    logic [FLAG_COUNT-1:0] rawFlags;
    logic [FLAG_COUNT-1:0] syncFlags;

    modport synchronizer (
        input  rawFlags,
        output syncFlags
    );

    modport consumer (
        output rawFlags,
        input  syncFlags
    );
endinterface : flag_sync_if

// file: hw/flag_synchronizer.sv
// Two-stage synchroniser for the level flags that arrive from the fabric.
`timescale 1ns/10ps
module flag_synchronizer
    import fabric_boot_pkg::*;
(
    input  wire logic clock,
    input  wire logic reset_n,
    flag_sync_if.synchronizer flags
);

    logic [FLAG_COUNT-1:0] stageOne_r;
    logic [FLAG_COUNT-1:0] stageTwo_r;
    logic [FLAG_COUNT-1:0] stageOne_nxt;
    logic [FLAG_COUNT-1:0] stageTwo_nxt;

    // ========================================================================
    // Per-flag stages
    // ========================================================================
    // The first stage feeds only the second; nothing else may look at it.
    genvar gi;
    generate
        for (gi = 0; gi < FLAG_COUNT; gi++) begin : g_flag
            always_comb begin
                stageOne_nxt[gi] = flags.rawFlags[gi];
                stageTwo_nxt[gi] = stageOne_r[gi];
            end
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            stageOne_r <= SYNC_RESET;
            stageTwo_r <= SYNC_RESET;
        end else begin
            stageOne_r <= stageOne_nxt;
            stageTwo_r <= stageTwo_nxt;
        end
    end

    assign flags.syncFlags = stageTwo_r;

endmodule // flag_synchronizer

// file: verification/fabric_boot_monitor.sv
// Concurrent checks on the ports of the fabric boot handshake.
`timescale 1ns/10ps
module fabric_boot_monitor
    import fabric_boot_pkg::*;
(
    input wire logic                        clock,
    input wire logic                        reset_n,
    input wire logic                        fabricConfigured,
    input wire logic                        fabricMemoryReadyFlag,
    input wire logic                        fallbackImageAvailableFlag,
    input wire logic                        fabricBootRequest,
    input wire logic                        allSourcesFailed,
    input wire logic                        publicKeyInFabric,
    input wire logic                        memoryReadyStatus,
    input wire logic                        fallbackAvailableStatus,
    input wire logic                        fabricBootGo,
    input wire logic                        pollActive,
    input wire logic                        keyReadEnable,
    input wire logic                        keyWithheld,
    input wire logic [POLL_COUNT_WIDTH-1:0] pollAttempts
);
    // The synchronisers hold reset values for a few edges, so pin checks wait until they are flushed.
    logic [2:0] upCnt_r;
    logic [2:0] upCnt_nxt;
    always_comb begin
        upCnt_nxt = (upCnt_r == 3'h7) ? upCnt_r : upCnt_r + 3'h1;
        if (!reset_n) upCnt_nxt = 3'h0;
    end
    always_ff @(posedge clock) begin
        upCnt_r <= upCnt_nxt;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_ready_follows_pins: assert property (upCnt_r >= 3'h4 |->
        memoryReadyStatus == $past(fabricConfigured && fabricMemoryReadyFlag, 3)) else $error("ready status wrong");
    a_fallback_follows_pins: assert property (upCnt_r >= 3'h4 |->
        fallbackAvailableStatus == $past(fabricConfigured && fallbackImageAvailableFlag, 3))
        else $error("fallback status wrong");
    a_go_needs_both: assert property (fabricBootGo |-> memoryReadyStatus && fallbackAvailableStatus)
        else $error("go without both flags");
    a_go_needs_request: assert property (fabricBootGo |-> $past(fabricBootRequest || allSourcesFailed))
        else $error("go without request");
    a_poll_not_go: assert property (!(pollActive && fabricBootGo)) else $error("poll and go together");
    a_poll_no_limit: assert property (pollActive && (fabricBootRequest || allSourcesFailed)
        |=> pollActive || fabricBootGo) else $error("polling stopped");
    a_first_sample: assert property ($rose(pollActive) && !$past(fabricBootGo) |->
        pollAttempts == 16'h0000 ##1 pollAttempts == 16'h0001) else $error("first sample wrong");
    a_key_read_ready: assert property (keyReadEnable |->
        memoryReadyStatus && $past(publicKeyInFabric) && !keyWithheld) else $error("key read not ready");
    a_key_held_back: assert property (keyWithheld |-> !memoryReadyStatus && $past(publicKeyInFabric))
        else $error("key withheld wrongly");
endmodule // fabric_boot_monitor

bind fabric_boot_ready_handshake fabric_boot_monitor mon (.clock(clock), .reset_n(reset_n),
    .fabricConfigured(fabricConfigured), .fabricMemoryReadyFlag(fabricMemoryReadyFlag),
    .fallbackImageAvailableFlag(fallbackImageAvailableFlag), .fabricBootRequest(fabricBootRequest),
    .allSourcesFailed(allSourcesFailed), .publicKeyInFabric(publicKeyInFabric),
    .memoryReadyStatus(memoryReadyStatus), .fallbackAvailableStatus(fallbackAvailableStatus),
    .fabricBootGo(fabricBootGo), .pollActive(pollActive), .keyReadEnable(keyReadEnable),
    .keyWithheld(keyWithheld), .pollAttempts(pollAttempts));

// file: verification/fabric_logic_model.sv
// Model of the fabric user logic that drives the two boot flags.
`timescale 1ns/10ps
module fabric_logic_model #(
    parameter int INIT_CYCLES = 4
) (
    input  wire logic clock,
    input  wire logic loadDone,
    input  wire logic imagePlaced,
    output logic      memReadyPin,
    output logic      fallbackPin
);
    // Memory needs a few cycles after loading before it accepts transactions.
    logic [3:0] initCnt_r = 4'h0;
    initial memReadyPin = 1'b0;
    initial fallbackPin = 1'b0;
    always @(posedge clock) begin
        initCnt_r <= !loadDone ? 4'h0 : (initCnt_r == 4'(INIT_CYCLES)) ? initCnt_r : initCnt_r + 4'h1;
        memReadyPin <= loadDone && (initCnt_r == 4'(INIT_CYCLES));
        fallbackPin <= imagePlaced;
    end
endmodule // fabric_logic_model

// file: verification/tb_top.sv
// Self-checking testbench for the fabric boot handshake.
`timescale 1ns/10ps
module tb_top;
    import fabric_boot_pkg::*;
    logic clock, reset_n, cfg, bootReq, failed, keyIn, loadDone, placed, memPin, fbPin;
    logic memSt, fbSt, go, polling, keyRd, keyHeld;
    logic [POLL_COUNT_WIDTH-1:0] attempts;
    int   errTotal = 0;
    int   numChecks = 0;
    fabric_logic_model #(.INIT_CYCLES(4)) fabric (.clock(clock), .loadDone(loadDone), .imagePlaced(placed),
        .memReadyPin(memPin), .fallbackPin(fbPin));
    fabric_boot_ready_handshake dut (.clock(clock), .reset_n(reset_n), .fabricConfigured(cfg),
        .fabricMemoryReadyFlag(memPin), .fallbackImageAvailableFlag(fbPin), .fabricBootRequest(bootReq),
        .allSourcesFailed(failed), .publicKeyInFabric(keyIn), .memoryReadyStatus(memSt),
        .fallbackAvailableStatus(fbSt), .fabricBootGo(go), .pollActive(polling), .keyReadEnable(keyRd),
        .keyWithheld(keyHeld), .pollAttempts(attempts));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // ========================================================================
    // Helpers
    // ========================================================================
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        numChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ========================================================================
    // Scenarios
    // ========================================================================
    task automatic test_gating();
        loadDone = 1'b1;
        placed = 1'b1;
        cyc(10);
        chk({memSt, fbSt}, 16'h0000);
        cfg = 1'b1;
        cyc(2);
        chk({memSt, fbSt}, 16'h0000);
        cyc(1);
        chk({memSt, fbSt}, 16'h0003);
        placed = 1'b0;
        cyc(4);
        chk({memSt, fbSt}, 16'h0002);
        placed = 1'b1;
        cyc(4);
        $display("test gating done");
    endtask
    task automatic test_boot();
        bootReq = 1'b1;
        cyc(1);
        chk({polling, go}, 16'h0002);
        chk(attempts, 16'h0000);
        cyc(1);
        chk({polling, go}, 16'h0001);
        chk(attempts, 16'h0001);
        bootReq = 1'b0;
        cyc(1);
        chk(go, 16'h0000);
        $display("test boot done");
    endtask
    task automatic test_fallback();
        int i;
        loadDone = 1'b0;
        placed = 1'b0;
        cyc(5);
        failed = 1'b1;
        keyIn = 1'b1;
        cyc(1);
        chk({polling, keyHeld, keyRd}, 16'h0006);
        cyc(100);
        chk(attempts, 16'h0001);
        cyc(1);
        chk(attempts, 16'h0002);
        placed = 1'b1;
        cyc(150);
        chk({go, polling}, 16'h0001);
        loadDone = 1'b1;
        for (i = 0; i < 300 && go !== 1'b1; i++) @(negedge clock);
        chk({go, keyRd, keyHeld}, 16'h0006);
        failed = 1'b0;
        keyIn = 1'b0;
        cyc(2);
        $display("test fallback done");
    endtask
    task automatic test_deconfig();
        bootReq = 1'b1;
        cyc(2);
        chk(go, 16'h0001);
        cfg = 1'b0;
        cyc(4);
        chk({go, polling, memSt, fbSt}, 16'h0004);
        bootReq = 1'b0;
        cyc(2);
        chk(polling, 16'h0000);
        $display("test deconfig done");
    endtask
    initial begin
        {reset_n, cfg, bootReq, failed, keyIn, loadDone, placed} = 7'h00;
        cyc(12);
        reset_n = 1'b1;
        cyc(1);
        chk({memSt, fbSt, go, polling, keyRd, keyHeld}, 16'h0000);
        chk(attempts, 16'h0000);
        test_gating();
        test_boot();
        test_fallback();
        test_deconfig();
        report_and_stop();
    end
    initial begin
        #20000;
        errTotal++;
        report_and_stop();
    end
endmodule // tb_top
